//--- verilog/touch_key_pkg.sv
// Package of constants shared by the touch key decision and output logic.
package touch_key_pkg;
   // Clock rate and derived millisecond tick.
   localparam int CLK_MHZ = 100;
   localparam int MS_TICK_US = 1000;
   localparam int MS_TICK_CYCLES = MS_TICK_US * CLK_MHZ;
   // Internal reset low period after the supply is good.
   localparam int POR_TIME_US = 600;
   localparam int POR_CYCLES = POR_TIME_US * CLK_MHZ;
   // Scan idle intervals in milliseconds.
   localparam logic [7:0] IDLE_LP_5V_MS = 8'he6;
   localparam logic [7:0] IDLE_LP_3V_MS = 8'h96;
   localparam logic [7:0] IDLE_NP_5V_MS = 8'h23;
   localparam logic [7:0] IDLE_NP_3V_MS = 8'h18;
   // Sensitivity codes, used as the margin the sense count must exceed.
   localparam logic [7:0] SENS_LP = 8'h12;
   localparam logic [7:0] SENS_NP = 8'h0c;
   // Strap agreement periods and debounce depth.
   localparam int STRAP_PERIODS = 4;
   localparam int DEBOUNCE_SCANS = 2;
   localparam int SENSE_W = 16;
   // Strap options.
   localparam logic [1:0] OPT_NONE = 2'h0;
   localparam logic [1:0] OPT_SUPPLY = 2'h1;
   localparam logic [1:0] OPT_FLOAT = 2'h2;
   localparam logic [1:0] OPT_GROUND = 2'h3;
   // Register byte offsets.
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;
   localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
   localparam logic [7:0] IRQ_CLR_OFS = 8'h0c;
   localparam logic [7:0] IRQ_EN_OFS = 8'h10;
   // Control field positions and reset value.
   localparam int CTRL_SUPPLY_3V_BIT = 0;
   localparam int CTRL_SCAN_EN_BIT = 1;
   localparam logic [1:0] CTRL_RESET = 2'h2;
   // Interrupt event bit positions.
   localparam int EV_PRESS = 0;
   localparam int EV_RELEASE = 1;
   localparam int EV_SUPPLY_LOSS = 2;
   localparam int EV_OPT_LOCK = 3;
   localparam int EV_W = 4;
   localparam logic [3:0] IRQ_EN_RESET = 4'h0;
   // Scan sequencer states.
   typedef enum logic [3:0] {
      ST_RESET = 4'b0001,
      ST_STRAP = 4'b0010,
      ST_IDLE = 4'b0100,
      ST_SCAN = 4'b1000
   } scan_state_t;
endpackage

//--- verilog/pin_sync.sv
// Three-stage pin synchroniser with second/third stage agreement filter.
`timescale 1ns/100ps
`default_nettype none
module pin_sync #(
   parameter int W = 1
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [W-1:0] pin_in,
   output logic [W-1:0] level_out
);
   logic [W-1:0] ff1_reg;
   logic [W-1:0] ff2_reg;
   logic [W-1:0] ff3_reg;

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         // The first stage feeds only the second; the output moves once stages two and three agree.
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               ff1_reg[i] <= 1'b0;
               ff2_reg[i] <= 1'b0;
               ff3_reg[i] <= 1'b0;
               level_out[i] <= 1'b0;
            end else begin
               ff1_reg[i] <= pin_in[i];
               ff2_reg[i] <= ff1_reg[i];
               ff3_reg[i] <= ff2_reg[i];
               if (ff2_reg[i] == ff3_reg[i]) begin
                  level_out[i] <= ff3_reg[i];
               end
            end
         end
      end
   endgenerate
endmodule
`default_nettype wire

//--- verilog/touch_key_output_ctrl.sv
// Touch key decision, strap decode, open-drain output and AHB-Lite register slave.
// Contract
// - Hold internal reset for power-on interval.
// - Supply loss drops indication and restarts reset.
// - Sense above reference declares touch, output low.
// - Initial touch with small sense stays unreported.
// - Output only sinks low or releases.
// - Toggle mode inverts output per new touch.
// - Strap sampled after reset, fixed until reset.
// - Supply strap: low power, 12h, long idle.
// - Ground strap: normal power, level, 0Ch.
// - Supply strap selects level output mode.
// - Floating strap: normal power, toggle, 0Ch.
//
// Design decisions made here: the register offsets and the AHB-Lite register port.
`timescale 1ns/100ps
`default_nettype none
module touch_key_output_ctrl
   import touch_key_pkg::*;
#(
   parameter int POR_CYC = POR_CYCLES,
   parameter int MS_CYC = MS_TICK_CYCLES,
   parameter int CW = SENSE_W
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   output logic irq,
   input wire logic supply_above_threshold,
   input wire logic strap_to_supply,
   input wire logic strap_to_ground,
   input wire logic [CW-1:0] sense_input,
   input wire logic [CW-1:0] reference_input,
   input wire logic meas_valid,
   output logic scan_req,
   output logic delayed_supply_ok,
   output logic internal_reset_n,
   output logic low_power_standby,
   output logic touch_out_o,
   output logic touch_out_oe
);
   logic supply_ok;
   logic strap_sup;
   logic strap_gnd;
   scan_state_t state_reg, state_next;
   logic [$clog2(POR_CYC+1)-1:0] por_cnt_reg;
   logic [$clog2(MS_CYC+1)-1:0] ms_cnt_reg;
   logic [7:0] idle_cnt_reg;
   logic [2:0] agree_cnt_reg;
   logic [1:0] opt_cand_reg;
   logic [1:0] opt_reg;
   logic [1:0] db_cnt_reg;
   logic touch_reg;
   logic toggle_reg;
   logic [1:0] ctrl_reg;
   logic [EV_W-1:0] irq_stat_reg;
   logic [EV_W-1:0] irq_en_reg;
   logic wr_pend_reg;
   logic [7:0] wr_addr_reg;

   // Pins from the analogue side are asynchronous to hclk.
   pin_sync #(.W(3)) u_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .pin_in({supply_above_threshold, strap_to_supply, strap_to_ground}),
      .level_out({supply_ok, strap_sup, strap_gnd})
   );

   // Timebase and option decode.
   wire ms_tick = (ms_cnt_reg == ($clog2(MS_CYC+1))'(MS_CYC - 1));
   wire por_done = (por_cnt_reg == ($clog2(POR_CYC+1))'(POR_CYC - 1));
   wire [1:0] strap_now = strap_sup ? OPT_SUPPLY : (strap_gnd ? OPT_GROUND : OPT_FLOAT);
   wire opt_lp = (opt_reg == OPT_SUPPLY);
   wire opt_toggle = (opt_reg == OPT_FLOAT);
   wire [7:0] sens_code = opt_lp ? SENS_LP : SENS_NP;
   wire supply_3v = ctrl_reg[CTRL_SUPPLY_3V_BIT];
   wire scan_en = ctrl_reg[CTRL_SCAN_EN_BIT];
   wire [7:0] idle_lp_ms = supply_3v ? IDLE_LP_3V_MS : IDLE_LP_5V_MS;
   wire [7:0] idle_np_ms = supply_3v ? IDLE_NP_3V_MS : IDLE_NP_5V_MS;
   wire [7:0] idle_ms = opt_lp ? idle_lp_ms : idle_np_ms;
   wire idle_done = ms_tick && (idle_cnt_reg >= idle_ms - 8'h01);
   wire in_reset = (state_reg == ST_RESET);

   // Touch decision: the sense count must exceed reference plus the sensitivity margin.
   // A touch present at power-up leaves sense far below reference and so never qualifies.
   wire [CW:0] thresh = {1'b0, reference_input} + {{(CW-8){1'b0}}, 1'b0, sens_code};
   wire raw_touch = ({1'b0, sense_input} > thresh);
   wire scan_hit = (state_reg == ST_SCAN) && meas_valid;
   wire db_agree = (raw_touch != touch_reg);
   wire db_flip = scan_hit && db_agree && (db_cnt_reg == 2'(DEBOUNCE_SCANS - 1));

   // Sequencer next state; a lost supply overrides everything.
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_RESET: begin
            if (por_done) begin
               state_next = ST_STRAP;
            end
         end
         ST_STRAP: begin
            if (ms_tick && agree_cnt_reg == 3'(STRAP_PERIODS - 1) && strap_now == opt_cand_reg) begin
               state_next = ST_IDLE;
            end
         end
         ST_IDLE: begin
            if (idle_done && scan_en) begin
               state_next = ST_SCAN;
            end
         end
         ST_SCAN: begin
            if (meas_valid) begin
               state_next = ST_IDLE;
            end
         end
         default: begin
            state_next = ST_RESET;
         end
      endcase
      if (!supply_ok) begin
         state_next = ST_RESET;
      end
   end

   // State register and power-on counter.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state_reg <= ST_RESET;
         por_cnt_reg <= '0;
      end else begin
         state_reg <= state_next;
         if (!supply_ok || !in_reset) begin
            por_cnt_reg <= '0;
         end else if (!por_done) begin
            por_cnt_reg <= por_cnt_reg + 1'b1;
         end
      end
   end

   // Millisecond divider and idle counter; the idle count restarts each scan.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ms_cnt_reg <= '0;
         idle_cnt_reg <= 8'h00;
      end else begin
         ms_cnt_reg <= ms_tick ? '0 : ms_cnt_reg + 1'b1;
         if (state_reg != ST_IDLE) begin
            idle_cnt_reg <= 8'h00;
         end else if (ms_tick && !idle_done) begin
            idle_cnt_reg <= idle_cnt_reg + 8'h01;
         end
      end
   end

   // Strap evaluation: the same option must be seen on several ticks, then it is held.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         agree_cnt_reg <= 3'h0;
         opt_cand_reg <= OPT_NONE;
         opt_reg <= OPT_NONE;
      end else if (in_reset) begin
         agree_cnt_reg <= 3'h0;
         opt_cand_reg <= OPT_NONE;
         opt_reg <= OPT_NONE;
      end else if (state_reg == ST_STRAP && ms_tick) begin
         opt_cand_reg <= strap_now;
         if (strap_now != opt_cand_reg) begin
            agree_cnt_reg <= 3'h0;
         end else if (agree_cnt_reg == 3'(STRAP_PERIODS - 1)) begin
            opt_reg <= strap_now;
         end else begin
            agree_cnt_reg <= agree_cnt_reg + 3'h1;
         end
      end
   end

   // Debounced touch flag and toggle state; both cleared while the internal reset runs.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         db_cnt_reg <= 2'h0;
         touch_reg <= 1'b0;
         toggle_reg <= 1'b0;
      end else if (state_reg == ST_RESET || state_reg == ST_STRAP) begin
         db_cnt_reg <= 2'h0;
         touch_reg <= 1'b0;
         toggle_reg <= 1'b0;
      end else if (scan_hit) begin
         if (!db_agree) begin
            db_cnt_reg <= 2'h0;
         end else if (db_flip) begin
            db_cnt_reg <= 2'h0;
            touch_reg <= raw_touch;
            if (raw_touch && opt_toggle) begin
               toggle_reg <= ~toggle_reg;
            end
         end else begin
            db_cnt_reg <= db_cnt_reg + 2'h1;
         end
      end
   end

   // Pin outputs. The data line is held low; only the enable moves, so the pin never drives high.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         touch_out_o <= 1'b0;
         touch_out_oe <= 1'b0;
         scan_req <= 1'b0;
         delayed_supply_ok <= 1'b0;
         internal_reset_n <= 1'b0;
         low_power_standby <= 1'b0;
      end else begin
         touch_out_o <= 1'b0;
         touch_out_oe <= (state_next == ST_IDLE || state_next == ST_SCAN) &&
                         (opt_toggle ? toggle_reg : touch_reg);
         scan_req <= (state_reg == ST_IDLE) && (state_next == ST_SCAN);
         delayed_supply_ok <= supply_ok;
         internal_reset_n <= (state_next != ST_RESET);
         // The standby flag drops on the same edge as the internal reset rather than
         // two cycles later, after the option register clears, so low power is never
         // reported while the sequencer restarts.
         low_power_standby <= opt_lp && (state_next != ST_RESET);
      end
   end

   // AHB-Lite decode. Zero wait states; every access is answered OKAY.
   wire addr_ok = hsel && hready && htrans[1];
   wire rd_take = addr_ok && !hwrite;
   wire wr_take = addr_ok && hwrite;
   wire [7:0] ofs = haddr[7:0];
   wire wr_ctrl = wr_pend_reg && (wr_addr_reg == CTRL_OFS);
   wire wr_clr = wr_pend_reg && (wr_addr_reg == IRQ_CLR_OFS);
   wire wr_en = wr_pend_reg && (wr_addr_reg == IRQ_EN_OFS);
   wire [31:0] status_word = {16'h0000, sens_code, 2'b00, opt_reg, low_power_standby,
                              touch_out_oe, toggle_reg, touch_reg};
   wire [31:0] rd_mux = (ofs == CTRL_OFS) ? {30'h0, ctrl_reg} :
                        (ofs == STATUS_OFS) ? status_word :
                        (ofs == IRQ_STAT_OFS) ? {28'h0, irq_stat_reg} :
                        (ofs == IRQ_EN_OFS) ? {28'h0, irq_en_reg} : 32'h0000_0000;

   // Interrupt events; a new event in the clearing cycle stays set.
   wire [EV_W-1:0] ev;
   assign ev[EV_PRESS] = db_flip && raw_touch;
   assign ev[EV_RELEASE] = db_flip && !raw_touch;
   assign ev[EV_SUPPLY_LOSS] = delayed_supply_ok && !supply_ok;
   assign ev[EV_OPT_LOCK] = (state_reg == ST_STRAP) && (state_next == ST_IDLE);
   wire [EV_W-1:0] clr_mask = wr_clr ? hwdata[EV_W-1:0] : '0;
   wire [EV_W-1:0] irq_stat_next = (irq_stat_reg & ~clr_mask) | ev;

   // Bus address phase capture and read data.
   // A write lands at the end of its data phase, the only cycle in which hwdata is valid.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_reg <= 1'b0;
         wr_addr_reg <= 8'h00;
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hreadyout <= 1'b1;
         hresp <= 1'b0;
         if (hready) begin
            wr_pend_reg <= wr_take;
            wr_addr_reg <= ofs;
         end
         if (rd_take) begin
            hrdata <= rd_mux;
         end
      end
   end

   // Software registers and interrupt line.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_reg <= CTRL_RESET;
         irq_en_reg <= IRQ_EN_RESET;
         irq_stat_reg <= '0;
         irq <= 1'b0;
      end else begin
         if (wr_ctrl) begin
            ctrl_reg <= hwdata[1:0];
         end
         if (wr_en) begin
            irq_en_reg <= hwdata[EV_W-1:0];
         end
         irq_stat_reg <= irq_stat_next;
         irq <= |(irq_stat_next & (wr_en ? hwdata[EV_W-1:0] : irq_en_reg));
      end
   end
endmodule
`default_nettype wire

//--- bench/touch_key_checker.sv
// Port checker for reset sequencing, scan spacing and the open-drain touch output.
`timescale 1ns/100ps
`default_nettype none
module touch_key_checker #(
   parameter int CW = 16
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic supply_above_threshold,
   input wire logic [CW-1:0] sense_input,
   input wire logic [CW-1:0] reference_input,
   input wire logic meas_valid,
   input wire logic scan_req,
   input wire logic delayed_supply_ok,
   input wire logic internal_reset_n,
   input wire logic low_power_standby,
   input wire logic touch_out_o,
   input wire logic touch_out_oe
);
   logic last_hi_reg;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // Keeps the last sense comparison, so a sink can be traced to a real touch.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         last_hi_reg <= 1'b0;
      end else if (meas_valid) begin
         last_hi_reg <= sense_input > reference_input;
      end
   end
   AST_SINK_ONLY: assert property (touch_out_o == 1'b0)
      else $error("touch output driven high");
   AST_RESET_QUIET: assert property (!internal_reset_n && !$past(internal_reset_n) |->
      !touch_out_oe && !scan_req && !low_power_standby) else $error("activity in reset");
   AST_LOSS_RESET: assert property ($fell(supply_above_threshold) |->
      ##[1:8] (!delayed_supply_ok && !internal_reset_n)) else $error("no reset on loss");
   AST_POR_HOLD: assert property ($rose(delayed_supply_ok) |->
      !internal_reset_n [*8] ##[1:40] internal_reset_n) else $error("reset period wrong");
   AST_SCAN_GAP: assert property (scan_req |=> !scan_req [*8])
      else $error("scans too close");
   AST_PRESS_CAUSE: assert property ($rose(touch_out_oe) |-> last_hi_reg)
      else $error("sink without touch");
   AST_LP_HELD: assert property ($fell(low_power_standby) |-> ##[0:2] !internal_reset_n)
      else $error("option changed outside reset");
   AST_NO_EARLY_SINK: assert property (touch_out_oe |-> internal_reset_n)
      else $error("sink during reset");
endmodule
bind touch_key_output_ctrl touch_key_checker #(.CW(CW)) chk (.hclk(hclk), .hresetn(hresetn),
   .supply_above_threshold(supply_above_threshold), .sense_input(sense_input),
   .reference_input(reference_input), .meas_valid(meas_valid), .scan_req(scan_req),
   .delayed_supply_ok(delayed_supply_ok), .internal_reset_n(internal_reset_n),
   .low_power_standby(low_power_standby), .touch_out_o(touch_out_o),
   .touch_out_oe(touch_out_oe));
`default_nettype wire

//--- bench/host_pin_model.sv
// Host input pin with a pull-up resistor on the open-drain touch output.
`timescale 1ns/100ps
`default_nettype none
module host_pin_model (
   input wire logic touch_out_o,
   input wire logic touch_out_oe,
   output logic pin_level
);
   // A released line rises to the pull-up; only an enabled sink pulls it low.
   assign pin_level = (touch_out_oe === 1'b1) ? touch_out_o : 1'b1;
endmodule
`default_nettype wire

//--- bench/test_touch_key_output_ctrl.sv
// Self-checking bench for the touch key decision and output block.
`timescale 1ns/100ps
`default_nettype none
module test_touch_key_output_ctrl;
   import touch_key_pkg::*;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hreadyout, hresp, irq, scan_req, dly_ok, irst_n, lp, out_o, out_oe, pin;
   logic sup = 1'b0;
   logic s_vdd = 1'b0;
   logic s_gnd = 1'b0;
   logic [15:0] sense = 16'h0100;
   logic [15:0] refc = 16'h0800;
   logic meas_valid = 1'b0;
   logic [31:0] q;
   int n_errors = 0;
   int check_count = 0;
   int w;
   // Strap cases in order: tied to supply, floating, tied to ground.
   logic [1:0] t_opt [3] = '{OPT_SUPPLY, OPT_FLOAT, OPT_GROUND};
   logic [7:0] t_sens [3] = '{SENS_LP, SENS_NP, SENS_NP};
   int t_ms [3] = '{230, 35, 35};
   always #5 hclk = ~hclk;
   // Short reset and millisecond counts keep the run small.
   touch_key_output_ctrl #(.POR_CYC(20), .MS_CYC(10)) dut (.hclk(hclk), .hresetn(hresetn),
      .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
      .hresp(hresp), .irq(irq), .supply_above_threshold(sup), .strap_to_supply(s_vdd),
      .strap_to_ground(s_gnd), .sense_input(sense), .reference_input(refc),
      .meas_valid(meas_valid), .scan_req(scan_req), .delayed_supply_ok(dly_ok),
      .internal_reset_n(irst_n), .low_power_standby(lp), .touch_out_o(out_o),
      .touch_out_oe(out_oe));
   host_pin_model host (.touch_out_o(out_o), .touch_out_oe(out_oe), .pin_level(pin));
   // The front end answers each scan request one cycle later.
   always @(posedge hclk) meas_valid <= scan_req;
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask
   // One single AHB-Lite transfer; read data lands in q.
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {24'h0, a};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      q = hrdata;
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge hclk);
   endtask
   // Sets the sense count above reference by delta and checks the pin later.
   task automatic press(input logic [15:0] delta, input logic exp_pin);
      @(posedge hclk);
      sense <= refc + delta;
      cyc(w);
      chk({31'h0, pin}, {31'h0, exp_pin});
   endtask
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // Cuts a hang short well past the expected run length.
   initial begin
      #900000;
      n_errors++;
      tally_and_finish;
   end
   initial begin
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      ahb(1'b0, CTRL_OFS, 32'h0);
      chk(q, {30'h0, CTRL_RESET});
      ahb(1'b0, IRQ_EN_OFS, 32'h0);
      chk(q, {28'h0, IRQ_EN_RESET});
      ahb(1'b1, 8'h40, 32'hffff);
      ahb(1'b0, 8'h40, 32'h0);
      chk(q, 32'h0);
      ahb(1'b1, CTRL_OFS, 32'h3);
      ahb(1'b0, CTRL_OFS, 32'h0);
      chk(q, 32'h3);
      ahb(1'b1, IRQ_EN_OFS, 32'h1);
      $display("test registers done");
      for (int i = 0; i < 3; i++) begin
         @(posedge hclk);
         s_vdd <= (i == 0);
         s_gnd <= (i == 2);
         sense <= 16'h0100;
         cyc(10);
         sup <= 1'b1;
         cyc(20);
         chk({31'h0, irst_n}, 32'h0);
         cyc(20);
         chk({31'h0, irst_n}, 32'h1);
         cyc(100);
         ahb(1'b0, STATUS_OFS, 32'h0);
         chk({24'h0, q[15:8]}, {24'h0, t_sens[i]});
         chk({29'h0, q[5:3]}, {29'h0, t_opt[i], i == 0});
         chk({31'h0, lp}, {31'h0, i == 0});
         chk({31'h0, pin}, 32'h1);
         // Moving the strap after lock must not change the options.
         s_vdd <= ~s_vdd;
         w = (t_ms[i] * 10 + 20) * 3;
         press(t_sens[i], 1'b1);
         press(t_sens[i] + 16'h1, 1'b0);
         chk({31'h0, irq}, 32'h1);
         ahb(1'b1, IRQ_CLR_OFS, 32'h1);
         ahb(1'b1, IRQ_EN_OFS, 32'h0);
         cyc(2);
         chk({31'h0, irq}, 32'h0);
         press(16'h0, i != 1);
         press(t_sens[i] + 16'h1, i == 1);
         chk({31'h0, irq}, 32'h0);
         ahb(1'b1, IRQ_EN_OFS, 32'h1);
         cyc(2);
         chk({31'h0, irq}, 32'h1);
         ahb(1'b1, IRQ_CLR_OFS, 32'h1);
         ahb(1'b0, STATUS_OFS, 32'h0);
         chk({30'h0, q[5:4]}, {30'h0, t_opt[i]});
         sup <= 1'b0;
         cyc(8);
         chk({29'h0, pin, irst_n, dly_ok}, 32'h4);
         $display("test strap %0d done", i);
      end
      tally_and_finish;
   end
endmodule
`default_nettype wire
